/* pkg/ispfp_pkg.sv */
// Constants and types shared by the serial flash programming slave
package ispfp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_SLV = 12'hF0B;
  localparam logic [11:0] IDX_EN = 12'hF0C;
  localparam logic [7:0] ENABLE_KEY = 8'h93;
  // Transfer type, low two bits of the first byte
  localparam logic [1:0] TY_CMD_WR = 2'h2;
  localparam logic [1:0] TY_CMD_RD = 2'h3;
  localparam logic [1:0] TY_DAT_WR = 2'h0;
  localparam logic [1:0] TY_DAT_RD = 2'h1;
  // Command codes
  localparam logic [4:0] CMD_PROG = 5'h14;
  localparam logic [4:0] CMD_ERASE = 5'h06;
  localparam logic [4:0] CMD_BLANK = 5'h0D;
  localparam logic [4:0] CMD_CLRCRC = 5'h1A;
  localparam logic [4:0] CMD_RESTART = 5'h09;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [2:0] IDX_SAT = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Timing at the system clock rate
  localparam int CLK_MHZ = 250;
  localparam int ENABLE_MIN_NS = 15000;
  localparam int ENABLE_MAX_NS = 22500;
  localparam int ERASE_MS = 10;
  localparam int PROG_US = 60;
  localparam int ENABLE_CYC = (ENABLE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam logic [11:0] ENABLE_CNT = 12'(ENABLE_CYC);
  typedef enum logic [2:0] {
    FR_IDLE, FR_RX, FR_AWAIT, FR_ACK, FR_TX, FR_TACK, FR_TNEXT
  } ispfp_fr_t;
endpackage

/* hw/ispfp_link.sv */
// Two-wire bit engine: start/stop, byte receive, acknowledge and transmit
`timescale 1ns/1ps
module ispfp_link import ispfp_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  input wire logic ack_en,
  input wire logic [7:0] tx_byte,
  output logic start_p,
  output logic stop_p,
  output logic byte_p,
  output logic [7:0] rx_byte,
  output logic tx_next_p
);
  typedef struct packed {
    logic scl1, scl2, sclp, sda1, sda2, sdap;
    ispfp_fr_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic oe, first, rd, st_p, sp_p, by_p, tn_p;
  } ispfp_lk_t;
  ispfp_lk_t q, d;
  logic rise, fall;

  always_comb begin
    d = q;
    d.scl1 = scl_i;
    d.scl2 = q.scl1;
    d.sclp = q.scl2;
    d.sda1 = sda_i;
    d.sda2 = q.sda1;
    d.sdap = q.sda2;
    d.st_p = 1'b0;
    d.sp_p = 1'b0;
    d.by_p = 1'b0;
    d.tn_p = 1'b0;
    rise = q.scl2 & ~q.sclp;
    fall = ~q.scl2 & q.sclp;
    case (q.st)
      FR_RX: if (rise) begin
        d.sh = {q.sh[6:0], q.sda2};
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == BIT_LAST) begin
          d.by_p = 1'b1;
          d.st = FR_AWAIT;
        end
      end
      FR_AWAIT: if (fall) begin
        d.oe = ack_en;
        d.st = ack_en ? FR_ACK : FR_IDLE;
        d.rd = q.rd | (q.first & q.sh[0]);
        d.first = 1'b0;
      end
      FR_ACK: if (fall) begin
        d.cnt = '0;
        d.sh = tx_byte;
        d.oe = q.rd & ~tx_byte[7];
        d.st = q.rd ? FR_TX : FR_RX;
      end
      FR_TX: if (fall) begin
        if (q.cnt == BIT_LAST) begin
          d.oe = 1'b0;
          d.st = FR_TACK;
        end else begin
          d.cnt = q.cnt + 3'h1;
          d.sh = {q.sh[6:0], 1'b0};
          d.oe = ~q.sh[6];
        end
      end
      // Host nack ends the read; wait for stop or start
      FR_TACK: if (rise) begin
        d.tn_p = ~q.sda2;
        d.st = q.sda2 ? FR_IDLE : FR_TNEXT;
      end
      FR_TNEXT: if (fall) begin
        d.cnt = '0;
        d.sh = tx_byte;
        d.oe = ~tx_byte[7];
        d.st = FR_TX;
      end
      default: d.oe = 1'b0;
    endcase
    if (q.scl2 && q.sclp && q.sdap && !q.sda2) begin
      d.st = FR_RX;
      d.cnt = '0;
      d.oe = 1'b0;
      d.first = 1'b1;
      d.rd = 1'b0;
      d.st_p = 1'b1;
    end else if (q.scl2 && q.sclp && !q.sdap && q.sda2) begin
      d.st = FR_IDLE;
      d.oe = 1'b0;
      d.sp_p = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{scl1: 1'b1, scl2: 1'b1, sclp: 1'b1, sda1: 1'b1, sda2: 1'b1, sdap: 1'b1,
             st: FR_IDLE, cnt: 3'h0, sh: 8'h00, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign sda_oe = q.oe;
  assign start_p = q.st_p;
  assign stop_p = q.sp_p;
  assign byte_p = q.by_p;
  assign rx_byte = q.sh;
  assign tx_next_p = q.tn_p;
endmodule // ispfp_link

/* hw/ispfp_top.sv */
// Serial flash programming slave: APB setup, command decode, CRC, flash timing
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module ispfp_top import ispfp_pkg::*; #(
  parameter logic [21:0] ERASE_CNT = 22'(ERASE_CYC),
  parameter logic [13:0] PROG_CNT = 14'(PROG_CYC)
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] flash_rdata,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_font,
  output logic flash_hi,
  output logic flash_prog,
  output logic flash_erase,
  output logic flash_blank,
  output logic flash_owned,
  output logic wdt_block,
  output logic cpu_restart
);
  typedef struct packed {
    logic rdy, err;
    logic [31:0] rd;
    logic [7:0] slv;
    logic en, act;
    logic [11:0] ecnt;
    logic [4:0] cmd;
    logic font, half;
    logic [7:0] page, low;
    logic [15:0] crc;
    logic [2:0] idx, txi;
    logic [1:0] ty;
    logic sel, ack;
    logic [7:0] tx;
    logic [21:0] ebusy;
    logic [13:0] pbusy;
    logic [15:0] fa;
    logic [7:0] wd;
    logic fhi, prog, erase, blank, rst, sdo;
  } ispfp_st_t;
  ispfp_st_t q, d;
  logic start_p, stop_p, byte_p, tx_next_p, link_oe;
  logic [7:0] rx;
  logic apb_acc, apb_wr, hit_slv, hit_en, match;

  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    logic checksum_feedback_bit;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      checksum_feedback_bit = r[15] ^ b[i];
      r = {r[14] ^ checksum_feedback_bit, r[13:2], r[1] ^ checksum_feedback_bit, r[0],
           checksum_feedback_bit};
    end
    return r;
  endfunction

  // Font words take two bytes per address, so step on the second
  function automatic logic [8:0] step(input logic font, input logic half,
                                     input logic [7:0] low);
    if (!font) return {1'b0, low + 8'h01};
    if (half) return {1'b0, 1'b0, low[6:0] + 7'h01};
    return {1'b1, low};
  endfunction

  function automatic logic [15:0] faddr(input logic font, input logic [7:0] pg,
                                        input logic [7:0] lo);
    return font ? {2'b00, pg[6:0], lo[6:0]} : {pg, lo};
  endfunction

  ispfp_link u_link (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe(link_oe),
    .ack_en(q.ack),
    .tx_byte(q.tx),
    .start_p(start_p),
    .stop_p(stop_p),
    .byte_p(byte_p),
    .rx_byte(rx),
    .tx_next_p(tx_next_p)
  );

  always_comb begin
    d = q;
    d.prog = 1'b0;
    d.erase = 1'b0;
    d.blank = 1'b0;
    d.rst = 1'b0;
    d.sdo = link_oe;
    apb_acc = psel & penable & ~q.rdy;
    apb_wr = psel & penable & q.rdy & pwrite;
    hit_slv = hit(paddr, IDX_SLV);
    hit_en = hit(paddr, IDX_EN);
    // One wait state, so every answer leaves a flop
    d.rdy = apb_acc;
    d.err = 1'b0;
    if (apb_acc) begin
      d.err = ~(hit_slv | hit_en);
      d.rd = '0;
      if (!pwrite && hit_slv) d.rd = {24'h0, q.slv};
      if (!pwrite && hit_en) d.rd = {30'h0, q.act, q.en};
    end
    if (apb_wr && hit_slv) d.slv = pwdata[7:0];
    if (apb_wr && hit_en) d.en = pwdata[7:0] == ENABLE_KEY;
    if (!q.en) begin
      d.ecnt = '0;
      d.act = 1'b0;
    end else if (!q.act) begin
      if (q.ecnt == ENABLE_CNT - 12'h001) d.act = 1'b1;
      else d.ecnt = q.ecnt + 12'h001;
    end
    if (q.ebusy != '0) d.ebusy = q.ebusy - 22'h000001;
    if (q.pbusy != '0) d.pbusy = q.pbusy - 14'h0001;
    if (start_p) begin
      d.idx = '0;
      d.sel = 1'b0;
      d.ack = 1'b0;
    end
    if (stop_p) d.sel = 1'b0;
    match = q.act && rx[7:2] == q.slv[5:0] && q.ebusy == '0;
    if (byte_p) begin
      d.ack = 1'b0;
      if (q.idx != IDX_SAT) d.idx = q.idx + 3'h1;
      if (q.idx == '0) begin
        d.ty = rx[1:0];
        d.sel = match;
        d.ack = match;
        d.txi = '0;
        if (match && rx[1:0] == TY_CMD_RD) d.tx = {q.cmd, 2'b00, q.font};
        // read starts at the low address
        if (match && rx[1:0] == TY_DAT_RD) begin
          d.tx = flash_rdata;
          {d.half, d.low} = step(q.font, q.half, q.low);
        end
      end else if (q.sel && q.ebusy == '0) begin
        case (q.ty)
          TY_CMD_WR: begin
            if (q.idx == 3'h1) begin
              d.ack = 1'b1;
              d.cmd = rx[7:3];
              d.font = rx[0];
              if (rx[7:3] == CMD_CLRCRC) d.crc = CRC_SEED;
              if (rx[7:3] == CMD_RESTART) begin
                d.rst = 1'b1;
                d.en = 1'b0;
                d.act = 1'b0;
              end
            end else if (q.idx == 3'h2) begin
              d.ack = 1'b1;
              d.page = rx;
            end
          end
          TY_DAT_WR: begin
            if (q.idx == 3'h1) begin
              d.ack = 1'b1;
              d.low = q.font ? {1'b0, rx[6:0]} : rx;
              d.half = 1'b0;
            end else if (q.cmd == CMD_ERASE || q.cmd == CMD_BLANK) begin
              if (q.idx == 3'h2) begin
                d.ack = 1'b1;
                d.erase = q.cmd == CMD_ERASE;
                d.blank = q.cmd == CMD_BLANK;
                d.ebusy = ERASE_CNT;
              end
            end else if (q.cmd == CMD_PROG && q.pbusy == '0) begin
              d.ack = 1'b1;
              d.prog = 1'b1;
              d.wd = rx;
              d.fhi = q.half;
              d.pbusy = PROG_CNT;
              d.crc = crc_byte(q.crc, rx);
              {d.half, d.low} = step(q.font, q.half, q.low);
            end
          end
          default: d.ack = 1'b0;
        endcase
      end
    end
    if (tx_next_p && q.sel) begin
      d.txi = q.txi + 3'h1;
      if (q.ty == TY_DAT_RD) begin
        d.tx = flash_rdata;
        {d.half, d.low} = step(q.font, q.half, q.low);
      end else begin
        case (q.txi)
          3'h0: d.tx = q.fa[15:8];
          3'h1: d.tx = q.fa[7:0];
          3'h2: d.tx = q.crc[15:8];
          3'h3: d.tx = q.crc[7:0];
          default: d.tx = IDLE_BYTE;
        endcase
      end
    end
    // Program strobe keeps the byte's own address; the step shows a cycle later
    if (!d.prog) d.fa = faddr(d.font, d.page, d.low);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{crc: CRC_SEED, default: '0};
    end else begin
      q <= d;
    end
  end

  assign pready = q.rdy;
  assign prdata = q.rd;
  assign pslverr = q.err;
  assign sda_o = 1'b0;
  assign sda_oe = q.sdo;
  assign flash_addr = q.fa;
  assign flash_wdata = q.wd;
  assign flash_font = q.font;
  assign flash_hi = q.fhi;
  assign flash_prog = q.prog;
  assign flash_erase = q.erase;
  assign flash_blank = q.blank;
  assign flash_owned = q.act;
  assign wdt_block = q.en;
  assign cpu_restart = q.rst;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  chk_enable_key: assert property (
    apb_wr && hit_en && pwdata[7:0] == ENABLE_KEY |=> wdt_block)
    else $error("enable key did not turn programming mode on");
  chk_handover_time: assert property (
    $rose(flash_owned) |-> $past(q.ecnt) == ENABLE_CNT - 12'h001 && wdt_block)
    else $error("flash handed over at the wrong time");
  chk_foreign_addr: assert property (
    byte_p && q.idx == '0 && rx[7:2] != q.slv[5:0] |=> !q.ack && !q.sel)
    else $error("foreign address acknowledged");
  chk_erase_nack: assert property (
    byte_p && q.ebusy != '0 |=> !q.ack)
    else $error("byte acknowledged during erase");
  chk_erase_len: assert property (
    $rose(flash_erase) |=> q.ebusy == ERASE_CNT - 22'h000001)
    else $error("erase busy time wrong");
  chk_prog_refuse: assert property (
    byte_p && q.pbusy != '0 && q.ty == TY_DAT_WR && q.idx > 3'h1 |=> $stable(q.low)
      && $stable(q.crc) && !q.ack)
    else $error("byte taken during program cycle");
  chk_crc_step: assert property (
    flash_prog |-> q.crc == crc_byte($past(q.crc), flash_wdata))
    else $error("checksum step mismatch");
  chk_crc_clear: assert property (
    byte_p && q.sel && q.ty == TY_CMD_WR && q.idx == 3'h1 && rx[7:3] == CMD_CLRCRC
      && q.ebusy == '0 |=> q.crc == CRC_SEED)
    else $error("checksum not preset");
  chk_restart_exit: assert property (
    cpu_restart |-> !wdt_block && !flash_owned ##1 !cpu_restart)
    else $error("restart left mode on");
  chk_prog_addr: assert property (
    flash_prog |-> flash_addr == faddr(flash_font, q.page, $past(q.low)))
    else $error("program strobe at wrong address");
  chk_code_step: assert property (
    flash_prog && !flash_font |-> q.low == $past(q.low) + 8'h01)
    else $error("code low address did not step");
  chk_font_hold: assert property (
    flash_prog && flash_font && !flash_hi |-> $stable(q.low))
    else $error("font low address stepped on first byte");
  chk_font_step: assert property (
    flash_prog && flash_font && flash_hi |-> q.low[6:0] == 7'($past(q.low) + 8'h01))
    else $error("font low address did not step");
  chk_read_step: assert property (
    tx_next_p && q.sel && q.ty == TY_DAT_RD && !q.font |=> q.low == $past(q.low) + 8'h01)
    else $error("read low address did not step");
  chk_type_latch: assert property (
    byte_p && q.idx == '0 && rx[1:0] == TY_CMD_RD |=> q.ty == TY_CMD_RD)
    else $error("transfer type not latched");
  chk_erase_crc: assert property (
    flash_erase || flash_blank |-> $stable(q.crc))
    else $error("erase byte entered the checksum");
  chk_idle_owner: assert property (
    byte_p && q.idx == '0 && !flash_owned |=> !q.ack && !q.sel)
    else $error("answered while flash not handed over");
endmodule // ispfp_top

/* testbench/ispfp_host.sv */
// Two-wire programming host model for the serial flash slave
`timescale 1ns/1ps
module ispfp_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  localparam int Q = 8;
  // Clock idles high between frames; data line left to pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    scl = 1'b0;
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q);
  endtask
  task automatic stop();
    scl = 1'b0;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b0;
    #(2*Q);
  endtask
  // Data changes only while clock low
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #(2*Q) s = sda_line;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Host acks all but the last read byte
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule // ispfp_host

/* testbench/isp_serial_flash_programmer_tb_top.sv */
// Self-checking bench for the serial flash programming slave
`timescale 1ns/1ps
module isp_serial_flash_programmer_tb_top;
  import ispfp_pkg::*;
  localparam logic [5:0] SA = 6'h2B;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, sda_o, sda_oe, scl, hpull;
  logic [31:0] prdata;
  logic [15:0] flash_addr;
  logic [7:0] flash_wdata;
  logic flash_font, flash_hi, flash_prog, flash_erase, flash_blank;
  logic flash_owned, wdt_block, cpu_restart;
  wire logic sda_line = ~(sda_oe | hpull);
  wire logic [7:0] flash_rdata = flash_addr[7:0] ^ flash_addr[15:8];
  int error_cnt = 0;
  int check_count = 0;
  int n_er = 0;
  int n_bl = 0;
  int n_rs = 0;
  logic [15:0] crc = CRC_SEED;
  logic [23:0] got_q[$];
  logic [23:0] exp_q[$];
  logic [1:0] fh_q[$];
  logic [1:0] efh_q[$];
  always #2 ref_clk = ~ref_clk;
  // Short erase and program counts keep the run brief
  ispfp_top #(.ERASE_CNT(22'h0C8), .PROG_CNT(14'h064)) dut (.ref_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .scl_i(scl),
    .sda_i(sda_line), .sda_o, .sda_oe, .flash_rdata, .flash_addr, .flash_wdata,
    .flash_font, .flash_hi, .flash_prog, .flash_erase, .flash_blank, .flash_owned,
    .wdt_block, .cpu_restart);
  ispfp_host host (.scl(scl), .sda_pull(hpull), .sda_line(sda_line));
  always @(posedge ref_clk) begin
    if (flash_prog === 1'b1) begin
      got_q.push_back({flash_addr, flash_wdata});
      fh_q.push_back({flash_font, flash_hi});
    end
    n_er += int'(flash_erase === 1'b1);
    n_bl += int'(flash_blank === 1'b1);
    n_rs += int'(cpu_restart === 1'b1);
  end
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    logic f;
    for (int i = 7; i >= 0; i--) begin
      f = c[15] ^ d[i];
      c = {c[14] ^ f, c[13:2], c[1] ^ f, c[0], f};
    end
    return c;
  endfunction
  task automatic chk(input logic [23:0] s, input logic [23:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cw(input logic [4:0] c, input logic f, input logic [7:0] pg);
    logic a;
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_CMD_WR}, a);
    chk(24'(a), 24'h1);
    host.wr({c, 2'b00, f}, a);
    chk(24'(a), 24'h1);
    host.wr(pg, a);
    chk(24'(a), 24'h1);
    host.stop();
  endtask
  task automatic dwo(input logic [7:0] lo);
    logic a;
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_DAT_WR}, a);
    chk(24'(a), 24'h1);
    host.wr(lo, a);
    chk(24'(a), 24'h1);
  endtask
  task automatic cr(input logic [7:0] c, input logic [16:0] ad);
    logic [7:0] b;
    logic a;
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_CMD_RD}, a);
    host.rd(1'b0, b);
    chk(24'(b), 24'(c));
    host.rd(1'b0, b);
    if (ad[16]) chk(24'(b), 24'(ad[15:8]));
    host.rd(1'b0, b);
    if (ad[16]) chk(24'(b), 24'(ad[7:0]));
    host.rd(1'b0, b);
    chk(24'(b), 24'(crc[15:8]));
    host.rd(1'b1, b);
    chk(24'(b), 24'(crc[7:0]));
    host.stop();
  endtask
  initial begin
    #300000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic e, a;
    logic [7:0] b;
    int n;
    n = $urandom(32'h21F8);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk(24'({wdt_block, flash_owned}), 24'h0);
    apb(1'b0, 16'h0010, 32'h0, r, e);
    chk(24'({e, r[7:0]}), 24'h100);
    chk(24'(sda_o), 24'h0);
    apb(1'b1, 16'h3C2C, 32'(SA), r, e);
    apb(1'b1, 16'h3C30, 32'h93, r, e);
    n = 0;
    while (flash_owned !== 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(24'(n >= ENABLE_CYC && n <= 5625), 24'h1);
    chk(24'(wdt_block), 24'h1);
    apb(1'b0, 16'h3C30, 32'h0, r, e);
    chk(24'(r), 24'h3);
    @(negedge ref_clk);
    host.start();
    host.wr({~SA, TY_CMD_WR}, a);
    host.stop();
    chk(24'(a), 24'h0);
    cw(CMD_PROG, 1'b0, 8'h12);
    dwo(8'h34);
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      host.wr(b, a);
      chk(24'(a), 24'(i < 4));
      if (a) begin
        exp_q.push_back({8'h12, 8'(8'h34 + i), b});
        efh_q.push_back(2'b00);
        crc = crc_step(crc, b);
      end
      // Host waits out the program cycle after the first three bytes only
      if (i < 3) #500;
    end
    host.stop();
    chk(24'(got_q.size()), 24'h4);
    foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
    cr({CMD_PROG, 3'b000}, {1'b1, 16'h1238});
    dwo(8'h34);
    host.start();
    host.wr({SA, TY_DAT_RD}, a);
    for (int i = 0; i < 3; i++) begin
      host.rd(i == 2, b);
      chk(24'(b), 24'((8'h34 + 8'(i)) ^ 8'h12));
    end
    host.stop();
    cw(CMD_PROG, 1'b1, 8'h05);
    dwo(8'h03);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      host.wr(b, a);
      chk(24'(a), 24'h1);
      crc = crc_step(crc, b);
      // Both bytes of a font word share one address
      exp_q.push_back({16'h0283, b});
      efh_q.push_back({1'b1, 1'(i)});
      #500;
    end
    host.stop();
    chk(24'(got_q.size()), 24'h6);
    foreach (exp_q[k]) if (k >= 4) chk(got_q[k], exp_q[k]);
    foreach (efh_q[k]) chk(24'(fh_q[k]), 24'(efh_q[k]));
    cr({CMD_PROG, 3'b001}, {1'b1, 16'h0284});
    cw(CMD_CLRCRC, 1'b0, 8'h00);
    crc = CRC_SEED;
    cr({CMD_CLRCRC, 3'b000}, 17'h0);
    cw(CMD_ERASE, 1'b0, 8'h20);
    dwo(8'h00);
    host.wr(8'hA5, a);
    chk(24'(a), 24'h1);
    host.stop();
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_CMD_RD}, a);
    host.stop();
    chk(24'(a), 24'h0);
    #1000;
    chk(24'(n_er), 24'h1);
    cr({CMD_ERASE, 3'b000}, 17'h0);
    cw(CMD_BLANK, 1'b0, 8'h00);
    dwo(8'h00);
    host.wr(8'h5A, a);
    chk(24'(a), 24'h1);
    host.stop();
    #1000;
    chk(24'(n_bl), 24'h1);
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_CMD_WR}, a);
    host.wr({CMD_RESTART, 3'b000}, a);
    host.stop();
    repeat (4) @(posedge ref_clk);
    chk(24'({n_rs[7:0], wdt_block}), 24'h2);
    // Slave must fall silent once the mode is left
    @(negedge ref_clk);
    host.start();
    host.wr({SA, TY_CMD_RD}, a);
    host.stop();
    chk(24'(a), 24'h0);
    give_verdict();
  end
endmodule // isp_serial_flash_programmer_tb_top
